// File: rtl/ffo_pkg.sv
package ffo_pkg;

   // ****************************************************************
   // sizes
   // ****************************************************************
   localparam int OFF_MAX     = 20;
   localparam int OFF_MIN     = 12;
   localparam int IDX_W       = 6;
   localparam int PTR_W       = 3;
   localparam int BUS_W       = 18;
   localparam int WIDE_LIMIT  = 16;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [OFF_MAX-1:0] OFF_RST = 20'h00000;
   localparam logic [IDX_W-1:0]   IDX_RST = 6'h00;
   localparam logic [PTR_W-1:0]   PTR_RST = 3'h0;
   localparam logic [BUS_W-1:0]   BUS_RST = 18'h00000;

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic               serial_mode;
      logic               in_x18;
      logic               out_x18;
      logic [OFF_MAX-1:0] empty_off;
      logic [OFF_MAX-1:0] full_off;
      logic               empty_ok;
      logic               full_ok;
      logic [IDX_W-1:0]   bit_idx;
      logic [PTR_W-1:0]   wptr;
      logic [PTR_W-1:0]   rptr;
      logic [BUS_W-1:0]   q;
      logic               q_valid;
      logic               rd_prev;
      logic               tog_seen;
   } ffo_core_t;

   typedef struct packed {
      logic tog;
      logic bit_hold;
   } ffo_link_t;

endpackage

// File: rtl/ffo_sync.sv
module ffo_sync
   import ffo_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } ffo_sync_t;

   ffo_sync_t st_r;
   ffo_sync_t st_nxt;

   initial begin
      if (WIDTH < 1) $error("ffo_sync width must be positive");
   end

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = d_in;
      st_nxt.s2 = st_r.s1;
      if (rst_in) begin
         st_nxt = '0;
      end
   end

   always_ff @(posedge clk_in) begin
      st_r <= st_nxt;
   end

   assign q_out = st_r.s2;

endmodule // ffo_sync

// File: rtl/ffo_offset_prog.sv
// Notes on behaviour
// (RULE_01) select low, shift enable low, write/read enables high: one serial bit per edge.
// (RULE_02) serial chain fills empty offset lsb first, ends at full offset msb.
// (RULE_03) host shifts 24..40 bits by variant; two fewer unless x9 both ways.
// (RULE_04) parallel words per offset: three for big x9, else two or one.
// (RULE_05) serial or parallel method latched during master reset only.
// (RULE_06) offsets always readable in parallel, whichever method is in force. Code drops a read requested in the cycle right after another.
// (RULE_07) sequence identical in standard and first word fall through timing.
// (RULE_08) select high: write enable writes memory, read enable reads; all high idle.
// (RULE_09) select low with shift enable high shifts nothing.
// (RULE_10) master reset puts both word pointers at empty low; partial reset keeps them.
// (RULE_11) select and write enable low: next offset word per edge, wraps after full.
//
// The strobed register port and the address map were left to the implementer.
module ffo_offset_prog
   import ffo_pkg::*;
#(
   parameter int OFFSET_BITS = OFF_MAX
) (
   input  wire logic               REF_CLK_IN,
   input  wire logic               RESET_IN,
   input  wire logic               SERIAL_CLK_IN,
   input  wire logic               OFFSET_LOAD_SELECT_N_IN,
   input  wire logic               SERIAL_SHIFT_ENABLE_N_IN,
   input  wire logic               SERIAL_DATA_IN,
   input  wire logic               WRITE_ENABLE_N_IN,
   input  wire logic               READ_ENABLE_N_IN,
   input  wire logic [BUS_W-1:0]   INPUT_WORD_BUS_IN,
   input  wire logic               SERIAL_SELECT_IN,
   input  wire logic               INPUT_X18_IN,
   input  wire logic               OUTPUT_X18_IN,
   output logic      [BUS_W-1:0]   OUTPUT_WORD_BUS_OUT,
   output logic                    OUTPUT_VALID_OUT,
   output logic      [OFF_MAX-1:0] EMPTY_OFFSET_OUT,
   output logic      [OFF_MAX-1:0] FULL_OFFSET_OUT,
   output logic                    EMPTY_OFFSET_VALID_OUT,
   output logic                    FULL_OFFSET_VALID_OUT,
   output logic                    SERIAL_MODE_OUT,
   output logic                    MEM_WRITE_OUT,
   output logic                    MEM_READ_OUT
);

   // ****************************************************************
   // elaboration check
   // ****************************************************************
   initial begin
      if (OFFSET_BITS < OFF_MIN || OFFSET_BITS > OFF_MAX) begin
         $error("OFFSET_BITS must lie between 12 and 20");
      end
   end

   // ****************************************************************
   // serial clock side
   // ****************************************************************
   ffo_link_t lk_r;
   ffo_link_t lk_nxt;
   logic      lk_rst;

   // reset reaches this side only while the serial clock runs
   ffo_sync #(
      .WIDTH (1)
   ) u_rst_sync (
      .clk_in (SERIAL_CLK_IN),
      .rst_in (1'b0),
      .d_in   (RESET_IN),
      .q_out  (lk_rst)
   );

   always_comb begin
      lk_nxt = lk_r;
      if (lk_rst) begin
         lk_nxt = '0;
      end else if (!SERIAL_SHIFT_ENABLE_N_IN) begin // RULE_09
         // bit held a whole serial period, far longer than the crossing
         lk_nxt.bit_hold = SERIAL_DATA_IN; // RULE_01
         lk_nxt.tog      = ~lk_r.tog;
      end
   end

   always_ff @(posedge SERIAL_CLK_IN) begin
      lk_r <= lk_nxt;
   end

   a_shift_gate: assert property ( // RULE_09
      @(posedge SERIAL_CLK_IN) disable iff (lk_rst)
      SERIAL_SHIFT_ENABLE_N_IN |=> $stable(lk_r.tog)
   ) else $error("serial bit taken with shift enable high");

   // ****************************************************************
   // crossings into the reference clock
   // ****************************************************************
   logic       tog_s;
   logic [2:0] strap_s;

   ffo_sync #(
      .WIDTH (1)
   ) u_tog_sync (
      .clk_in (REF_CLK_IN),
      .rst_in (RESET_IN),
      .d_in   (lk_r.tog),
      .q_out  (tog_s)
   );

   ffo_sync #(
      .WIDTH (3)
   ) u_strap_sync (
      .clk_in (REF_CLK_IN),
      .rst_in (1'b0),
      .d_in   ({SERIAL_SELECT_IN, INPUT_X18_IN, OUTPUT_X18_IN}),
      .q_out  (strap_s)
   );

   // ****************************************************************
   // decode
   // ****************************************************************
   ffo_core_t        st_r;
   ffo_core_t        st_nxt;
   logic [IDX_W-1:0] ow;
   logic [PTR_W-1:0] wpo;
   logic [PTR_W-1:0] rpo;
   logic [PTR_W-1:0] wk;
   logic [PTR_W-1:0] rk;
   logic             tog_event;
   logic             ser_apply;
   logic             par_wr;
   logic             rd_off;
   logic [OFF_MAX-1:0] rd_src;
   logic [OFF_MAX-1:0] rd_shift;

   // offset width drops by one unless both ports are x9
   assign ow = (st_r.in_x18 || st_r.out_x18) ? IDX_W'(OFFSET_BITS - 1)
                                             : IDX_W'(OFFSET_BITS); // RULE_03

   // an x9 word carries 8 offset bits, an x18 word 16
   assign wpo = st_r.in_x18  ? ((ow > IDX_W'(WIDE_LIMIT)) ? 3'h2 : 3'h1)
                             : ((ow > IDX_W'(WIDE_LIMIT)) ? 3'h3 : 3'h2); // RULE_04
   assign rpo = st_r.out_x18 ? ((ow > IDX_W'(WIDE_LIMIT)) ? 3'h2 : 3'h1)
                             : ((ow > IDX_W'(WIDE_LIMIT)) ? 3'h3 : 3'h2);

   assign wk = (st_r.wptr < wpo) ? st_r.wptr : st_r.wptr - wpo;
   assign rk = (st_r.rptr < rpo) ? st_r.rptr : st_r.rptr - rpo;

   assign tog_event = tog_s ^ st_r.tog_seen;

   // no timing mode input: flag timing never alters the sequence
   assign ser_apply = tog_event && st_r.serial_mode && !OFFSET_LOAD_SELECT_N_IN
                      && WRITE_ENABLE_N_IN && READ_ENABLE_N_IN; // RULE_01 RULE_07
   assign par_wr    = !st_r.serial_mode && !OFFSET_LOAD_SELECT_N_IN
                      && !WRITE_ENABLE_N_IN; // RULE_11
   // of back to back offset reads only the first is taken, the second one is dropped
   assign rd_off    = !OFFSET_LOAD_SELECT_N_IN && !READ_ENABLE_N_IN
                      && !st_r.rd_prev; // RULE_06

   assign MEM_WRITE_OUT = OFFSET_LOAD_SELECT_N_IN && !WRITE_ENABLE_N_IN; // RULE_08
   assign MEM_READ_OUT  = OFFSET_LOAD_SELECT_N_IN && !READ_ENABLE_N_IN; // RULE_08

   assign rd_src   = (st_r.rptr < rpo) ? st_r.empty_off : st_r.full_off;
   assign rd_shift = st_r.out_x18 ? rd_src >> {rk, 4'h0} : rd_src >> {rk, 3'h0};

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      st_nxt          = st_r;
      st_nxt.tog_seen = tog_s;
      st_nxt.q_valid  = 1'b0;
      st_nxt.rd_prev  = !OFFSET_LOAD_SELECT_N_IN && !READ_ENABLE_N_IN;
      if (RESET_IN) begin
         st_nxt.serial_mode = strap_s[2]; // RULE_05
         st_nxt.in_x18      = strap_s[1];
         st_nxt.out_x18     = strap_s[0];
         st_nxt.empty_off   = OFF_RST;
         st_nxt.full_off    = OFF_RST;
         st_nxt.empty_ok    = 1'b0;
         st_nxt.full_ok     = 1'b0;
         st_nxt.bit_idx     = IDX_RST;
         st_nxt.wptr        = PTR_RST; // RULE_10
         st_nxt.rptr        = PTR_RST; // RULE_10
         st_nxt.q           = BUS_RST;
         st_nxt.rd_prev     = 1'b0;
      end else begin
         // ------ serial chain, empty lsb first, full msb last
         if (ser_apply) begin
            for (int i = 0; i < OFF_MAX; i++) begin
               if (IDX_W'(i) == st_r.bit_idx && IDX_W'(i) < ow) begin
                  st_nxt.empty_off[i] = lk_r.bit_hold; // RULE_02
               end
               if (IDX_W'(i) + ow == st_r.bit_idx && IDX_W'(i) < ow) begin
                  st_nxt.full_off[i] = lk_r.bit_hold; // RULE_02
               end
            end
            if (st_r.bit_idx == IDX_RST) begin
               st_nxt.empty_ok = 1'b0;
               st_nxt.full_ok  = 1'b0;
            end
            // a fresh complete set may be shifted again at any time
            if (st_r.bit_idx == (ow << 1) - IDX_W'(1)) begin // RULE_03
               st_nxt.bit_idx  = IDX_RST;
               st_nxt.empty_ok = 1'b1;
               st_nxt.full_ok  = 1'b1;
            end else begin
               st_nxt.bit_idx = st_r.bit_idx + IDX_W'(1);
            end
         end
         // ------ parallel words, empty offset first
         if (par_wr) begin
            for (int i = 0; i < OFF_MAX; i++) begin
               if (IDX_W'(i) < ow) begin
                  if (st_r.in_x18 ? (PTR_W'(i >> 4) == wk) : (PTR_W'(i >> 3) == wk)) begin
                     if (st_r.wptr < wpo) begin
                        st_nxt.empty_off[i] = st_r.in_x18 ? INPUT_WORD_BUS_IN[i % 16]
                                                          : INPUT_WORD_BUS_IN[i % 8]; // RULE_04
                     end else begin
                        st_nxt.full_off[i] = st_r.in_x18 ? INPUT_WORD_BUS_IN[i % 16]
                                                         : INPUT_WORD_BUS_IN[i % 8];
                     end
                  end
               end
            end
            if (st_r.wptr == PTR_RST) begin
               st_nxt.empty_ok = 1'b0;
            end
            if (st_r.wptr == wpo - PTR_W'(1)) begin
               st_nxt.empty_ok = 1'b1;
            end
            if (st_r.wptr == wpo) begin
               st_nxt.full_ok = 1'b0;
            end
            if (st_r.wptr == (wpo << 1) - PTR_W'(1)) begin
               st_nxt.full_ok = 1'b1;
               st_nxt.wptr    = PTR_RST; // RULE_11
            end else begin
               st_nxt.wptr = st_r.wptr + PTR_W'(1); // RULE_11
            end
         end
         // ------ parallel read back, independent pointer
         if (rd_off) begin
            st_nxt.q       = st_r.out_x18 ? {2'h0, rd_shift[15:0]}
                                          : {10'h000, rd_shift[7:0]}; // RULE_06
            st_nxt.q_valid = 1'b1;
            if (st_r.rptr == (rpo << 1) - PTR_W'(1)) begin
               st_nxt.rptr = PTR_RST;
            end else begin
               st_nxt.rptr = st_r.rptr + PTR_W'(1);
            end
         end
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      st_r <= st_nxt;
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign OUTPUT_WORD_BUS_OUT    = st_r.q;
   assign OUTPUT_VALID_OUT       = st_r.q_valid;
   assign EMPTY_OFFSET_OUT       = st_r.empty_off;
   assign FULL_OFFSET_OUT        = st_r.full_off;
   assign EMPTY_OFFSET_VALID_OUT = st_r.empty_ok;
   assign FULL_OFFSET_VALID_OUT  = st_r.full_ok;
   assign SERIAL_MODE_OUT        = st_r.serial_mode;

   // ****************************************************************
   // checks
   // ****************************************************************
   a_ptr_reset: assert property ( // RULE_10
      @(posedge REF_CLK_IN) disable iff (RESET_IN)
      $fell(RESET_IN) |-> st_r.wptr == PTR_RST && st_r.rptr == PTR_RST
   ) else $error("pointers not at empty low after reset");

   a_mode_fixed: assert property ( // RULE_05
      @(posedge REF_CLK_IN) disable iff (RESET_IN)
      !$past(RESET_IN) |-> $stable(SERIAL_MODE_OUT)
   ) else $error("programming method changed outside reset");

   a_serial_step: assert property ( // RULE_01
      @(posedge REF_CLK_IN) disable iff (RESET_IN)
      ser_apply && st_r.bit_idx == IDX_RST |=> st_r.bit_idx == 6'h01
   ) else $error("serial index did not advance");

   a_serial_first: assert property ( // RULE_02
      @(posedge REF_CLK_IN) disable iff (RESET_IN)
      ser_apply && st_r.bit_idx == IDX_RST |=> EMPTY_OFFSET_OUT[0] == $past(lk_r.bit_hold)
   ) else $error("first serial bit not in empty lsb");

   a_serial_full: assert property ( // RULE_03
      @(posedge REF_CLK_IN) disable iff (RESET_IN)
      ser_apply && st_r.bit_idx == (ow << 1) - IDX_W'(1)
      |=> st_r.bit_idx == IDX_RST && FULL_OFFSET_VALID_OUT
   ) else $error("serial set did not complete at its length");

   a_par_first: assert property ( // RULE_04
      @(posedge REF_CLK_IN) disable iff (RESET_IN)
      par_wr && st_r.wptr == PTR_RST && !st_r.in_x18
      |=> EMPTY_OFFSET_OUT[7:0] == $past(INPUT_WORD_BUS_IN[7:0])
   ) else $error("first parallel word not in empty low byte");

   a_par_wrap: assert property ( // RULE_11
      @(posedge REF_CLK_IN) disable iff (RESET_IN)
      par_wr && st_r.wptr == (wpo << 1) - PTR_W'(1) |=> st_r.wptr == PTR_RST
   ) else $error("write pointer did not wrap after full offset");

   a_read_any: assert property ( // RULE_06
      @(posedge REF_CLK_IN) disable iff (RESET_IN)
      !OFFSET_LOAD_SELECT_N_IN && !READ_ENABLE_N_IN && !st_r.rd_prev
      |=> OUTPUT_VALID_OUT ##1 !OUTPUT_VALID_OUT
   ) else $error("offset read not answered");

   a_mem_idle: assert property ( // RULE_08
      @(posedge REF_CLK_IN) disable iff (RESET_IN)
      OFFSET_LOAD_SELECT_N_IN |=> $stable(EMPTY_OFFSET_OUT) && $stable(FULL_OFFSET_OUT)
   ) else $error("offsets changed during memory access");

   a_par_blocked: assert property ( // RULE_05
      @(posedge REF_CLK_IN) disable iff (RESET_IN)
      SERIAL_MODE_OUT && !WRITE_ENABLE_N_IN |=> $stable(st_r.wptr)
   ) else $error("parallel write taken in serial mode");

endmodule // ffo_offset_prog

// File: verification/ffo_host_model.sv
module ffo_host_model (
   output logic serial_clk_out,
   output logic shift_enable_n_out,
   output logic serial_data_out
);
   timeunit 1ns;
   timeprecision 100ps;

   // ****************************************************************
   // serial frames: clock stands still between frames
   // ****************************************************************
   initial begin
      serial_clk_out     = 1'b0;
      shift_enable_n_out = 1'b1;
      serial_data_out    = 1'b0;
   end

   // n bits lsb first; en low toggles the clock with shift enable high
   task automatic shift_bits(input logic [39:0] bits, input int n, input logic en);
      #1;
      for (int i = 0; i < n; i++) begin
         shift_enable_n_out = ~en;
         serial_data_out    = en ? bits[i] : ~serial_data_out;
         #32 serial_clk_out = 1'b1;
         #32 serial_clk_out = 1'b0;
      end
      shift_enable_n_out = 1'b1;
      // released line must not keep showing the last bit
      serial_data_out    = ~serial_data_out;
   endtask

endmodule // ffo_host_model

// File: verification/testbench.sv
`define FFO_CHECK(nm, e, g) begin \
   n_compared++; \
   if ((g) !== (e)) begin \
      error_cnt++; \
      $display("wrong value %s expected %h seen %h", nm, e, g); \
   end \
end

module testbench
   import ffo_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ****************************************************************
   // signals
   // ****************************************************************
   logic               clk;
   logic               rst;
   logic               sel_n;
   logic               wen_n;
   logic               ren_n;
   logic               sser;
   logic               in18;
   logic               out18;
   logic [BUS_W-1:0]   din;
   logic [BUS_W-1:0]   qout;
   logic               qvalid;
   logic [OFF_MAX-1:0] eoff;
   logic [OFF_MAX-1:0] foff;
   logic               ev;
   logic               fv;
   logic               smode;
   logic               mw;
   logic               mr;
   wire                sclk;
   wire                sen_n;
   wire                sdata;
   int                 error_cnt  = 0;
   int                 n_compared = 0;
   // writes: high words carry junk above bit 19 to prove masking
   logic [7:0]         pw [7] = '{8'hc1, 8'ha3, 8'hf5, 8'h29, 8'h7e, 8'h3c, 8'h11};
   logic [7:0]         pr [7] = '{8'h11, 8'ha3, 8'h05, 8'h29, 8'h7e, 8'h0c, 8'h11};
   // {sel_n, wen_n, ren_n, mem write, mem read}
   logic [4:0]         md [5] = '{5'b10110, 5'b11001, 5'b11100, 5'b01100, 5'b10011};
   logic [39:0]        ser    = {20'h3b1d7, 20'ha5c3e};

   ffo_offset_prog ffo_offset_prog_inst (
      .REF_CLK_IN               (clk),
      .RESET_IN                 (rst),
      .SERIAL_CLK_IN            (sclk),
      .OFFSET_LOAD_SELECT_N_IN  (sel_n),
      .SERIAL_SHIFT_ENABLE_N_IN (sen_n),
      .SERIAL_DATA_IN           (sdata),
      .WRITE_ENABLE_N_IN        (wen_n),
      .READ_ENABLE_N_IN         (ren_n),
      .INPUT_WORD_BUS_IN        (din),
      .SERIAL_SELECT_IN         (sser),
      .INPUT_X18_IN             (in18),
      .OUTPUT_X18_IN            (out18),
      .OUTPUT_WORD_BUS_OUT      (qout),
      .OUTPUT_VALID_OUT         (qvalid),
      .EMPTY_OFFSET_OUT         (eoff),
      .FULL_OFFSET_OUT          (foff),
      .EMPTY_OFFSET_VALID_OUT   (ev),
      .FULL_OFFSET_VALID_OUT    (fv),
      .SERIAL_MODE_OUT          (smode),
      .MEM_WRITE_OUT            (mw),
      .MEM_READ_OUT             (mr)
   );

   ffo_host_model host_inst (
      .serial_clk_out     (sclk),
      .shift_enable_n_out (sen_n),
      .serial_data_out    (sdata)
   );

   // ****************************************************************
   // clock and access tasks
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // serial side resets through a synchroniser, so give it idle edges
   task automatic do_reset(input logic [2:0] s);
      @(posedge clk);
      rst   <= 1'b1;
      {sser, in18, out18} <= s;
      sel_n <= 1'b1;
      wen_n <= 1'b1;
      ren_n <= 1'b1;
      host_inst.shift_bits(40'h0, 4, 1'b0);
      @(posedge clk);
      rst <= 1'b0;
      // serial side leaves reset only on its own edges
      host_inst.shift_bits(40'h0, 4, 1'b0);
      @(posedge clk);
   endtask

   task automatic wr_word(input logic [15:0] b);
      @(posedge clk);
      sel_n <= 1'b0;
      wen_n <= 1'b0;
      din   <= {2'h0, b};
      @(posedge clk);
      sel_n <= 1'b1;
      wen_n <= 1'b1;
      din   <= ~{2'h0, b};
   endtask

   // a spare cycle follows, as back-to-back reads are refused
   task automatic rd_word(input logic [7:0] b);
      @(posedge clk);
      sel_n <= 1'b0;
      ren_n <= 1'b0;
      @(posedge clk);
      sel_n <= 1'b1;
      ren_n <= 1'b1;
      #1;
      `FFO_CHECK("read valid", 1'b1, qvalid)
      `FFO_CHECK("read word", {10'h000, b}, qout)
   endtask

   task automatic end_of_test;
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #100000;
      error_cnt++;
      end_of_test;
   end

   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      rst   = 1'b1;
      sel_n = 1'b1;
      wen_n = 1'b1;
      ren_n = 1'b1;
      sser  = 1'b0;
      in18  = 1'b0;
      out18 = 1'b0;
      din   = BUS_RST;
      do_reset(3'h0);
      #1;
      `FFO_CHECK("parallel mode", 1'b0, smode)
      `FFO_CHECK("empty reset", 20'h00000, eoff)
      for (int i = 0; i < 6; i++) wr_word({8'h00, pw[i]});
      repeat (2) @(posedge clk);
      `FFO_CHECK("empty par", 20'h5a3c1, eoff)
      `FFO_CHECK("full par", 20'hc7e29, foff)
      wr_word({8'h00, pw[6]});
      repeat (2) @(posedge clk);
      `FFO_CHECK("empty wrap", 20'h5a311, eoff)
      foreach (pr[i]) rd_word(pr[i]);
      foreach (md[i]) begin
         @(posedge clk);
         {sel_n, wen_n, ren_n} <= md[i][4:2];
         #1;
         `FFO_CHECK("mem write", md[i][1], mw)
         `FFO_CHECK("mem read", md[i][0], mr)
      end
      @(posedge clk);
      {sel_n, wen_n, ren_n} <= 3'h7;
      #1;
      `FFO_CHECK("empty kept", 20'h5a311, eoff)

      // second reset mid-run, serial method; strap moves afterwards
      do_reset(3'h4);
      {sser, in18, out18} <= 3'h3;
      wr_word(16'h00ff);
      repeat (4) @(posedge clk);
      `FFO_CHECK("serial mode", 1'b1, smode)
      `FFO_CHECK("par refused", 20'h00000, eoff)
      sel_n <= 1'b0;
      host_inst.shift_bits(ser, 20, 1'b1);
      repeat (8) @(posedge clk);
      `FFO_CHECK("empty ser", 20'ha5c3e, eoff)
      `FFO_CHECK("empty valid mid", 1'b0, ev)
      host_inst.shift_bits(ser, 5, 1'b0);
      repeat (8) @(posedge clk);
      `FFO_CHECK("full idle", 20'h00000, foff)
      host_inst.shift_bits(ser >> 20, 20, 1'b1);
      repeat (8) @(posedge clk);
      `FFO_CHECK("full ser", 20'h3b1d7, foff)
      `FFO_CHECK("empty still", 20'ha5c3e, eoff)
      `FFO_CHECK("full valid", 1'b1, fv)
      `FFO_CHECK("empty valid", 1'b1, ev)
      `FFO_CHECK("mode held", 1'b1, smode)
      sel_n <= 1'b1;
      rd_word(8'h3e);
      rd_word(8'h5c);
      rd_word(8'h0a);

      // x18 in, x9 out: 19-bit offsets, two words in, three out
      do_reset(3'h2);
      wr_word(16'hbeef);
      wr_word(16'hfffd);
      repeat (2) @(posedge clk);
      `FFO_CHECK("empty valid par", 1'b1, ev)
      `FFO_CHECK("full valid par", 1'b0, fv)
      wr_word(16'h1234);
      wr_word(16'h0002);
      repeat (2) @(posedge clk);
      `FFO_CHECK("empty x18", 20'h5beef, eoff)
      `FFO_CHECK("full x18", 20'h21234, foff)
      `FFO_CHECK("full valid x18", 1'b1, fv)
      rd_word(8'hef);
      rd_word(8'hbe);
      rd_word(8'h05);
      rd_word(8'h34);
      end_of_test;
   end

endmodule // testbench
